// File: src/lfdc_ctrl.sv
`timescale 1ns/10ps
`include "lfdc_params.svh"

// Functional notes
// R1: mode band in sixths of supply picks behaviour and fmax; middle two bands (2 and 3) idle.
// R2: switching frequency capped at one of two maxima, each per mains rate.
// R3: mode parameters follow detected 50 Hz or 60 Hz mains.
// R4: average LED current per half mains cycle compared with reference.
// R5: peak setpoint updated once per half mains cycle toward reference.
// R6: leading-edge blanking adapts automatically against switch-on transients.
// R7: end of demagnetisation and valleys found by dV/dt; turn on at valley.
// R8: demagnetisation detector ignored for a blanking time at stroke start.
// R9: no new cycle before demagnetisation ended; boundary conduction forced.
// R10: in boundary conduction raise peak setpoint first, then stroke time.
// R11: switching begins only after supply exceeds start-up level.
// R12: supply below lockout stops switching and resets control state.
// R13: after blanking, switch off when source sense reaches peak threshold.
// R14: thermal above high level gives full LED current.
// R15: between thermal levels LED target derates linearly by 25 percent.
// R16: thermal below low level enters standby with zero current.
// R17: standby ends only when thermal rises above high level.
// R18: winding fault after blanking stops switching until power-on reset.
// R19: long secondary stroke with short on-time in one mains wave shuts down.
// R20: supply overvoltage (open LED) shuts down until power-on reset.
// R21: all comparator flags pass two flip-flop stages before use.
module lfdc_ctrl
#(
   parameter int unsigned IPK_W = `LFDC_IPK_W
)
(
   input  wire logic             ref_clk_in,
   input  wire logic             nrst_in,
   input  wire logic [2:0]       mode_band_in,       // sixths exceeded, 0..5
   input  wire logic             mains_60hz_in,
   input  wire logic             mains_zero_in,      // half-cycle boundary
   input  wire logic             supply_start_in,
   input  wire logic             supply_lockout_in,
   input  wire logic             supply_ovp_in,
   input  wire logic             peak_current_in,
   input  wire logic             winding_fault_in,
   input  wire logic             demag_end_in,
   input  wire logic             valley_in,
   input  wire logic             thermal_high_in,    // above high level
   input  wire logic             thermal_low_in,     // above low level
   input  wire logic             led_above_ref_in,   // avg above reference
   input  wire logic [6:0]       thermal_frac_in,    // 0..100 position in band
   output logic                  switch_on_out,
   output logic [IPK_W-1:0]      peak_setpoint_out,
   output logic                  low_ripple_out,
   output logic                  fmax_high_out,
   output logic                  standby_out,
   output logic                  fault_out,
   output logic [6:0]            led_target_pct_out
);
   if (IPK_W < 4 || IPK_W > 16)
   begin : g_ipk_w_bad
      $error("lfdc_ctrl: IPK_W out of range");
   end

   localparam int LEB_MIN   = `LFDC_NS_CYC_UP(`LFDC_LEB_MIN_NS);
   localparam int LEB_MAX   = `LFDC_NS_CYC_UP(`LFDC_LEB_MAX_NS);
   localparam int DBLANK    = `LFDC_NS_CYC_UP(`LFDC_DEMAG_BLANK_NS);
   localparam int SHORT_T   = `LFDC_NS_CYC_UP(`LFDC_SHORT_DET_NS);
   localparam int TON_HIGH  = `LFDC_NS_CYC_DN(`LFDC_TON_HIGH_NS);
   localparam int P_LO50    = `LFDC_PER_CYC(`LFDC_FMAX_LO_50_KHZ);
   localparam int P_LO60    = `LFDC_PER_CYC(`LFDC_FMAX_LO_60_KHZ);
   localparam int P_HI50    = `LFDC_PER_CYC(`LFDC_FMAX_HI_50_KHZ);
   localparam int P_HI60    = `LFDC_PER_CYC(`LFDC_FMAX_HI_60_KHZ);

   ////////////////////////////////////////////////////////////////////////////
   // synchronised flags
   logic [20:0] raw;
   logic [20:0] syn;
   logic [6:0]  frac;                        // multi-bit: source must hold still while it settles
   logic [2:0]  band;
   logic        m60, mzero, s_start, s_lock, s_ovp, pk, wf, dm, vl, th_hi, th_lo;

   assign raw = {thermal_frac_in, mode_band_in, mains_60hz_in, mains_zero_in, supply_start_in, supply_lockout_in,
                 supply_ovp_in, peak_current_in, winding_fault_in, demag_end_in, valley_in,
                 thermal_high_in, thermal_low_in};
   lfdc_sync #(.WIDTH(21)) u_sync
   (
      .ref_clk_in (ref_clk_in),
      .nrst_in    (nrst_in),
      .async_in   (raw),
      .sync_out   (syn)                                                              // R21
   );
   assign {frac, band, m60, mzero, s_start, s_lock, s_ovp, pk, wf, dm, vl, th_hi, th_lo} = syn;
   logic above_m;
   logic above_s;

   ////////////////////////////////////////////////////////////////////////////
   // supervisor state
   lfdc_pkg::lfdc_sup_t sup;
   lfdc_pkg::lfdc_sup_t next_sup;
   logic                mode_ok;
   logic                short_hit;
   logic                wf_hit;

   assign mode_ok = (band != 3'd2) && (band != 3'd3) && (band <= 3'd5);               // R1

   // latched faults beat everything; lockout resets control state
   always_comb
   begin
      next_sup = sup;
      case (sup)
         lfdc_pkg::LFDC_OFF:
            if (s_start && !s_lock)
               next_sup = lfdc_pkg::LFDC_RUN;                                          // R11
         lfdc_pkg::LFDC_RUN:
            if (!th_lo)
               next_sup = lfdc_pkg::LFDC_STANDBY;                                      // R16
         lfdc_pkg::LFDC_STANDBY:
            if (th_hi)
               next_sup = lfdc_pkg::LFDC_RUN;                                          // R17
         lfdc_pkg::LFDC_LATCHED,
         lfdc_pkg::LFDC_SHUT:
            next_sup = sup;
         default:
            next_sup = lfdc_pkg::LFDC_OFF;
      endcase
      if ((sup == lfdc_pkg::LFDC_RUN || sup == lfdc_pkg::LFDC_STANDBY) && s_lock)
         next_sup = lfdc_pkg::LFDC_OFF;                                                // R12
      if (sup != lfdc_pkg::LFDC_LATCHED && sup != lfdc_pkg::LFDC_SHUT)
      begin
         if (wf_hit)
            next_sup = lfdc_pkg::LFDC_LATCHED;                                         // R18
         else if (s_ovp || short_hit)
            next_sup = lfdc_pkg::LFDC_SHUT;                                            // R19 R20
      end
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (!nrst_in)
         sup <= lfdc_pkg::LFDC_OFF;
      else
         sup <= next_sup;
   end

   ////////////////////////////////////////////////////////////////////////////
   // switching cycle
   lfdc_pkg::lfdc_sw_t sw;
   lfdc_pkg::lfdc_sw_t next_sw;
   logic [15:0]        cnt, next_cnt;        // time in current stroke
   logic [15:0]        per, next_per;        // time since last turn-on
   logic [15:0]        ton, next_ton;        // last primary on-time
   logic [15:0]        leb, next_leb;        // adaptive blanking
   logic [15:0]        min_per;
   logic               bcm, next_bcm;        // valley in first wait cycle, after min period
   logic               sw_on, next_sw_on;
   logic               run;

   assign run = (sup == lfdc_pkg::LFDC_RUN) && mode_ok;
   assign wf_hit = (sw == lfdc_pkg::LFDC_ON) && (cnt >= leb) && wf;                    // R18
   assign min_per = fmax_high_out ? (m60 ? 16'(P_HI60) : 16'(P_HI50))                   // R2 R3
                                  : (m60 ? 16'(P_LO60) : 16'(P_LO50));

   always_comb
   begin
      next_sw    = sw;
      next_cnt   = (cnt == 16'hFFFF) ? cnt : cnt + 16'h0001;
      next_per   = (per == 16'hFFFF) ? per : per + 16'h0001;
      next_ton   = ton;
      next_leb   = leb;
      next_bcm   = bcm;
      next_sw_on = 1'b0;
      case (sw)
         lfdc_pkg::LFDC_IDLE:
            if (run && per >= min_per)
            begin
               next_sw  = lfdc_pkg::LFDC_ON;
               next_cnt = 16'h0000;
               next_per = 16'h0000;
               next_sw_on = 1'b1;
            end
         lfdc_pkg::LFDC_ON:
         begin
            next_sw_on = 1'b1;
            // blanking grows if peak flag is already up at its end, shrinks otherwise
            if (cnt == leb)
               next_leb = pk ? ((leb < 16'(LEB_MAX)) ? leb + 16'h0001 : leb)            // R6
                             : ((leb > 16'(LEB_MIN)) ? leb - 16'h0001 : leb);
            if (cnt >= leb && (pk || cnt >= 16'(TON_HIGH)))                              // R13
            begin
               next_sw    = lfdc_pkg::LFDC_DEMAG;
               next_ton   = cnt;
               next_cnt   = 16'h0000;
               next_sw_on = 1'b0;
            end
         end
         lfdc_pkg::LFDC_DEMAG:
            if (cnt >= 16'(DBLANK) && dm)                                                // R8 R9
            begin
               next_sw  = lfdc_pkg::LFDC_WAIT;
               next_cnt = 16'h0000;
            end
         lfdc_pkg::LFDC_WAIT:
            if (vl)                                                                      // R7
            begin
               next_bcm = (per >= min_per) && (cnt == 16'h0000);                         // R10
               if (run && per >= min_per)
               begin
                  next_sw    = lfdc_pkg::LFDC_ON;
                  next_cnt   = 16'h0000;
                  next_per   = 16'h0000;
                  next_sw_on = 1'b1;
               end
            end
            else if (!run)
               next_sw = lfdc_pkg::LFDC_IDLE;
         default:
            next_sw = lfdc_pkg::LFDC_IDLE;
      endcase
      if (!run || wf_hit)
      begin
         next_sw    = (sw == lfdc_pkg::LFDC_ON) ? lfdc_pkg::LFDC_DEMAG : next_sw;
         next_sw_on = 1'b0;
         if (sw == lfdc_pkg::LFDC_IDLE)
            next_sw = lfdc_pkg::LFDC_IDLE;
      end
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (!nrst_in || sup == lfdc_pkg::LFDC_OFF)                                         // R12
      begin
         sw    <= lfdc_pkg::LFDC_IDLE;
         cnt   <= 16'h0000;
         per   <= 16'hFFFF;
         ton   <= 16'h0000;
         leb   <= 16'(LEB_MIN);
         bcm   <= 1'b0;
         sw_on <= 1'b0;
      end
      else
      begin
         sw    <= next_sw;
         cnt   <= next_cnt;
         per   <= next_per;
         ton   <= next_ton;
         leb   <= next_leb;
         bcm   <= next_bcm;
         sw_on <= next_sw_on;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // half mains cycle regulation and short detection
   logic              mz_d, next_mz_d;
   logic              half_edge;
   logic              short_seen, next_short_seen;
   logic [IPK_W-1:0]  ipk, next_ipk;
   logic              low_ripple, next_low_ripple;
   logic              fmax_high, next_fmax_high;
   logic              standby, next_standby;
   logic              fault, next_fault;
   logic [6:0]        tgt, next_tgt;

   assign half_edge = mzero && !mz_d;
   assign short_hit = half_edge && short_seen;

   always_comb
   begin
      next_mz_d       = mzero;
      next_short_seen = short_seen;
      next_ipk        = ipk;
      // long secondary stroke while on-time stays short, within one half mains cycle
      if (sw == lfdc_pkg::LFDC_DEMAG && cnt > 16'(SHORT_T) && ton < 16'(TON_HIGH))
         next_short_seen = 1'b1;                                                         // R19
      if (half_edge)
      begin
         next_short_seen = 1'b0;
         // bcm forces an increase even when the average is already above
         if ((!above_s || bcm) && ipk != (IPK_W)'(`LFDC_IPK_MAX))                        // R4 R5 R10
            next_ipk = ipk + (IPK_W)'(1);
         else if (above_s && !bcm && ipk != (IPK_W)'(`LFDC_IPK_MIN))
            next_ipk = ipk - (IPK_W)'(1);
      end
      next_low_ripple = (band <= 3'd1);                                                  // R1
      next_fmax_high  = (band == 3'd0) || (band == 3'd5);                                // R1 R2
      next_standby    = (sup == lfdc_pkg::LFDC_STANDBY);
      next_fault      = (sup == lfdc_pkg::LFDC_LATCHED) || (sup == lfdc_pkg::LFDC_SHUT);
      if (sup != lfdc_pkg::LFDC_RUN)
         next_tgt = 7'd0;                                                                // R16
      else if (th_hi)
         next_tgt = 7'd100;                                                              // R14
      else
         next_tgt = 7'(100 - `LFDC_DERATE_PCT) + 7'((14'(frac) * 14'(`LFDC_DERATE_PCT)) / 14'd100); // R15
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (!nrst_in || sup == lfdc_pkg::LFDC_OFF)
      begin
         mz_d       <= 1'b0;
         short_seen <= 1'b0;
         ipk        <= (IPK_W)'(`LFDC_IPK_RST);
      end
      else
      begin
         mz_d       <= next_mz_d;
         short_seen <= next_short_seen;
         ipk        <= next_ipk;
      end
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (!nrst_in)
      begin
         above_m    <= 1'b0;
         above_s    <= 1'b0;
         low_ripple <= 1'b0;
         fmax_high  <= 1'b0;
         standby    <= 1'b0;
         fault      <= 1'b0;
         tgt        <= 7'd0;
      end
      else
      begin
         above_m    <= led_above_ref_in;
         above_s    <= above_m;                                                          // R21
         low_ripple <= next_low_ripple;
         fmax_high  <= next_fmax_high;
         standby    <= next_standby;
         fault      <= next_fault;
         tgt        <= next_tgt;
      end
   end

   assign switch_on_out      = sw_on;
   assign peak_setpoint_out  = ipk;
   assign low_ripple_out     = low_ripple;
   assign fmax_high_out      = fmax_high;
   assign standby_out        = standby;
   assign fault_out          = fault;
   assign led_target_pct_out = tgt;
endmodule // lfdc_ctrl

// File: src/lfdc_params.svh
`ifndef LFDC_PARAMS_SVH
`define LFDC_PARAMS_SVH
// controller clock, kHz
`define LFDC_CLK_KHZ         25000
// mode pin band codes from the sixths comparator ladder (count of sixths exceeded)
`define LFDC_BAND_W          3
// maximum switching frequencies, kHz
`define LFDC_FMAX_LO_50_KHZ  50
`define LFDC_FMAX_LO_60_KHZ  60
`define LFDC_FMAX_HI_50_KHZ  100
`define LFDC_FMAX_HI_60_KHZ  120
// minimum period in clock cycles, rounded up
`define LFDC_PER_CYC(f)      ((`LFDC_CLK_KHZ + (f) - 1) / (f))
// timing figures in ns and derived cycles
`define LFDC_LEB_MIN_NS      300
`define LFDC_LEB_MAX_NS      600
`define LFDC_DEMAG_BLANK_NS  1000
`define LFDC_SHORT_DET_NS    10000
`define LFDC_TON_HIGH_NS     16700
`define LFDC_NS_CYC_UP(t)    (((t) * 25 + 999) / 1000)
`define LFDC_NS_CYC_DN(t)    (((t) * 25) / 1000)
// peak setpoint width, reset value and limits
`define LFDC_IPK_W           8
`define LFDC_IPK_RST         8'h0080
`define LFDC_IPK_MIN         8'h0010
`define LFDC_IPK_MAX         8'h00FF
// derating span: 25 percent of target at thermal low level
`define LFDC_DERATE_PCT      25
`endif

// File: src/lfdc_pkg.sv
package lfdc_pkg;
   typedef enum logic [4:0]
   {
      LFDC_OFF     = 5'b0_0001,
      LFDC_RUN     = 5'b0_0010,
      LFDC_STANDBY = 5'b0_0100,
      LFDC_LATCHED = 5'b0_1000,
      LFDC_SHUT    = 5'b1_0000
   } lfdc_sup_t;
   typedef enum logic [3:0]
   {
      LFDC_IDLE  = 4'b0001,
      LFDC_ON    = 4'b0010,
      LFDC_DEMAG = 4'b0100,
      LFDC_WAIT  = 4'b1000
   } lfdc_sw_t;
endpackage

// File: src/lfdc_sync.sv
`timescale 1ns/10ps
// two-stage synchroniser per bit
module lfdc_sync
#(
   parameter int WIDTH = 8
)
(
   input  wire logic             ref_clk_in,
   input  wire logic             nrst_in,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] next_meta;
   logic [WIDTH-1:0] next_sync;

   ////////////////////////////////////////////////////////////////////////////
   // first stage feeds only the second
   always_comb
   begin
      next_meta = async_in;
      next_sync = meta;
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (!nrst_in)
      begin
         meta     <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta     <= next_meta;
         sync_out <= next_sync;
      end
   end
endmodule // lfdc_sync

// File: verification/lfdc_ctrl_chk.sv
`timescale 1ns/10ps
module lfdc_ctrl_chk
#(
   parameter int unsigned IPK_W = 8
)
(
   input wire logic             ref_clk_in,
   input wire logic             nrst_in,
   input wire logic [2:0]       mode_band_in,
   input wire logic             supply_start_in,
   input wire logic             supply_lockout_in,
   input wire logic             supply_ovp_in,
   input wire logic             peak_current_in,
   input wire logic             demag_end_in,
   input wire logic             switch_on_out,
   input wire logic [IPK_W-1:0] peak_setpoint_out,
   input wire logic             low_ripple_out,
   input wire logic             fmax_high_out,
   input wire logic             standby_out,
   input wire logic             fault_out,
   input wire logic [6:0]       led_target_pct_out
);
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!nrst_in);
   logic [9:0] on_cnt, next_on_cnt, gap, next_gap;
   logic       started, next_started, seen, next_seen, rise;
   ////////////////////////////////////////////////////////////////
   // on-time, spacing of turn-ons, start and demag history
   assign rise = switch_on_out && on_cnt == 10'h000;
   always_comb
   begin
      next_on_cnt  = switch_on_out ? on_cnt + 10'h001 : 10'h000;
      next_gap     = rise ? 10'h001 : gap + {9'h000, gap != 10'h3FF};
      next_started = started | supply_start_in;
      next_seen    = rise ? 1'b0 : seen | demag_end_in; // raw flag leads the synced one
   end
   always_ff @(posedge ref_clk_in)
   begin
      if (!nrst_in)
      begin
         on_cnt  <= 10'h000;
         gap     <= 10'h3FF;
         started <= 1'b0;
         seen    <= 1'b1;
      end
      else
      begin
         on_cnt  <= next_on_cnt;
         gap     <= next_gap;
         started <= next_started;
         seen    <= next_seen;
      end
   end
   ////////////////////////////////////////////////////////////////
   // a band held long enough to pass the synchroniser
   sequence band_held(logic [2:0] b);
      (mode_band_in == b)[*5];
   endsequence
   sequence peak_held;
      (on_cnt > 10'h014 && peak_current_in) ##1 peak_current_in;
   endsequence
   band_hi_a: assert property (band_held(3'h5) |-> !low_ripple_out && fmax_high_out)
      else $error("band five decode wrong");
   band_lr_a: assert property (band_held(3'h1) |-> low_ripple_out && !fmax_high_out)
      else $error("band one decode wrong");
   min_period_a: assert property (rise |-> gap >= 10'h0D1)
      else $error("turn-on faster than fastest cap");
   demag_first_a: assert property (rise |-> seen)
      else $error("turn-on before demag end");
   start_gate_a: assert property (switch_on_out |-> started)
      else $error("switching before start level");
   lockout_stop_a: assert property (supply_lockout_in[*8] |-> !switch_on_out)
      else $error("switching under lockout");
   peak_off_a: assert property (peak_held |-> ##2 !switch_on_out)
      else $error("switch kept on past peak");
   ton_limit_a: assert property (on_cnt <= 10'h1A4)
      else $error("on-time beyond limit");
   standby_zero_a: assert property (standby_out |-> led_target_pct_out == 7'h00)
      else $error("current target in standby");
   fault_hold_a: assert property (fault_out |=> fault_out)
      else $error("fault latch released");
   fault_quiet_a: assert property (fault_out ##1 fault_out |-> !switch_on_out)
      else $error("switching while shut down");
   ovp_shut_a: assert property ($rose(supply_ovp_in) && started |-> ##[1:6] fault_out)
      else $error("overvoltage not shut down");
   setp_step_a: assert property ($changed(peak_setpoint_out) |->
      peak_setpoint_out == $past(peak_setpoint_out) + 1'b1 ||
      peak_setpoint_out + 1'b1 == $past(peak_setpoint_out))
      else $error("setpoint moved by more than one");
endmodule // lfdc_ctrl_chk

bind lfdc_ctrl lfdc_ctrl_chk #(.IPK_W(IPK_W)) i_chk (.ref_clk_in, .nrst_in, .mode_band_in, .supply_start_in,
   .supply_lockout_in, .supply_ovp_in, .peak_current_in, .demag_end_in, .switch_on_out, .peak_setpoint_out,
   .low_ripple_out, .fmax_high_out, .standby_out, .fault_out, .led_target_pct_out);

// File: verification/lfdc_stage_model.sv
`timescale 1ns/10ps
// flyback stage as seen through its comparators
module lfdc_stage_model
(
   input  wire logic       ref_clk_in,
   input  wire logic       switch_on_in,
   input  wire logic [9:0] ramp_in,         // on cycles until peak
   input  wire logic [9:0] demag_in,        // off cycles until demag end
   output logic            peak_current_out,
   output logic            demag_end_out,
   output logic            valley_out
);
   logic [9:0] cnt  = 10'h000;
   logic       prev = 1'b0;
   // stroke counter, saturating so an idle stage stays settled
   always_ff @(posedge ref_clk_in)
   begin
      prev <= switch_on_in;
      cnt  <= (switch_on_in != prev) ? 10'h000 : cnt + {9'h000, cnt != 10'h3FF};
   end
   // peak holds until switch-off, so a late turn-off is not forgiven
   // counter restarts one edge after a switch change, so gate on a settled switch
   assign peak_current_out = switch_on_in && prev && cnt >= ramp_in;
   assign demag_end_out    = !switch_on_in && !prev && cnt >= demag_in;
   assign valley_out       = demag_end_out && cnt[2:0] == 3'h0;
endmodule // lfdc_stage_model

// File: verification/testbench.sv
`timescale 1ns/10ps
module testbench;
   logic       clk = 1'b0, nrst = 1'b0, m60 = 1'b0, mzero = 1'b0, s_start = 1'b0, s_lock = 1'b0;
   logic       s_ovp = 1'b0, wfault = 1'b0, th_hi = 1'b1, th_lo = 1'b1, above = 1'b0;
   logic [2:0] band = 3'h5;
   logic [6:0] frac = 7'h64;
   logic [9:0] ramp = 10'h01E, dly = 10'h014;
   logic       sw, pk, dm, vl, lr, fh, sb, flt;
   logic [7:0] setp;
   logic [6:0] tgt;
   int         mismatches = 0, total_checks = 0, n, p;
   always #20 clk = ~clk;
   lfdc_stage_model i_stage (.ref_clk_in(clk), .switch_on_in(sw), .ramp_in(ramp), .demag_in(dly),
      .peak_current_out(pk), .demag_end_out(dm), .valley_out(vl));
   lfdc_ctrl i_dut (.ref_clk_in(clk), .nrst_in(nrst), .mode_band_in(band), .mains_60hz_in(m60),
      .mains_zero_in(mzero), .supply_start_in(s_start), .supply_lockout_in(s_lock), .supply_ovp_in(s_ovp),
      .peak_current_in(pk), .winding_fault_in(wfault), .demag_end_in(dm), .valley_in(vl),
      .thermal_high_in(th_hi), .thermal_low_in(th_lo), .led_above_ref_in(above), .thermal_frac_in(frac),
      .switch_on_out(sw), .peak_setpoint_out(setp), .low_ripple_out(lr), .fmax_high_out(fh),
      .standby_out(sb), .fault_out(flt), .led_target_pct_out(tgt));
   ////////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   // inputs always move one ns after the rising edge
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   // cycles until the next turn-on, bounded
   task automatic wait_on(output int c);
      c = 0;
      while (sw === 1'b1 && c < 2000)
      begin
         tick(1);
         c++;
      end
      while (sw !== 1'b1 && c < 2000)
      begin
         tick(1);
         c++;
      end
   endtask
   task automatic do_reset;
      nrst = 1'b0;
      tick(10);
      nrst = 1'b1;
      tick(3);
   endtask
   task automatic half_cycle;
      mzero = 1'b1;
      tick(10);
      mzero = 1'b0;
      tick(10);
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   initial
   begin
      do_reset;
      check(setp, 8'h80);
      check({flt, sb, sw, 5'h00}, 8'h00);
      check({1'b0, tgt}, 8'h00);
      tick(50);
      check(sw, 1'b0);
      s_start = 1'b1;
      s_lock = 1'b1;
      tick(50);
      check(sw, 1'b0);
      s_lock = 1'b0;
      wait_on(n);
      check(sw, 1'b1);
      $display("test start done");
      // switching bands 0, 1, 4 and 5 at each mains rate: decode and turn-on spacing
      for (int i = 0; i < 8; i++)
      begin
         band = (i[2:1] == 2'h0) ? 3'h0 : (i[2:1] == 2'h1) ? 3'h1 : (i[2:1] == 2'h2) ? 3'h4 : 3'h5;
         m60 = i[0];
         p = (i[2:1] == 2'h1 || i[2:1] == 2'h2) ? (m60 ? 417 : 500) : (m60 ? 209 : 250);
         repeat (3) wait_on(n);
         check({lr, fh}, {i[2:1] < 2'h2, i[2:1] != 2'h1 && i[2:1] != 2'h2});
         check(n >= p, 1'b1);
         check(n <= p + 30, 1'b1);
      end
      band = 3'h2;
      tick(600);
      wait_on(n);
      check(n == 2000, 1'b1);
      $display("test modes done");
      band = 3'h5;
      above = 1'b1;
      half_cycle;
      check(setp, 8'h7F);
      above = 1'b0;
      half_cycle;
      half_cycle;
      check(setp, 8'h81);
      $display("test setpoint done");
      check(tgt, 7'h64);
      th_hi = 1'b0;
      frac = 7'h00;
      tick(8);
      check(tgt, 7'h4B);
      frac = 7'h32;
      tick(8);
      check(tgt, 7'h57);
      th_lo = 1'b0;
      tick(8);
      check({sb, tgt}, 8'h80);
      th_lo = 1'b1;
      tick(8);
      check(sb, 1'b1);
      th_hi = 1'b1;
      tick(8);
      check({sb, tgt}, 8'h64);
      $display("test thermal done");
      // winding fault, overvoltage, long secondary stroke
      for (int k = 0; k < 3; k++)
      begin
         do_reset;
         wait_on(n);
         tick(25);
         wfault = (k == 0);
         s_ovp = (k == 1);
         dly = (k == 2) ? 10'h12C : 10'h014;
         tick(5);
         wfault = 1'b0;
         s_ovp = 1'b0;
         tick(900);
         half_cycle;
         tick(50);
         check(flt, 1'b1);
         wait_on(n);
         check(sw, 1'b0);
         dly = 10'h014;
      end
      $display("test faults done");
      complete_run;
   end
   initial
   begin
      #2000000;
      mismatches++;
      complete_run;
   end
endmodule // testbench
